// ### rtl/ssr_pkg.sv
// Constants, field positions and command codes of the status reporter.
// Assumes a single clock domain; shared by design and bench.
package ssr_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;

    // ------------------------------------------------------------
    // Measurement-warning register layout
    // ------------------------------------------------------------
    localparam int WARN_LIMIT_HIGH_BIT = 12;
    localparam int WARN_LIMIT_LOW_BIT = 11;
    localparam int WARN_CAP_OVERLOAD_BIT = 10;
    localparam int WARN_OVERLOAD_BIT = 9;
    localparam logic [15:0] WARN_USED_MASK = 16'h1e00;
    localparam logic [15:0] OP_LIVE_VALUE = 16'h0000;
    localparam logic [15:0] ENABLE_STORE_MASK = 16'h7fff;
    localparam logic [15:0] MASK16_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Status byte layout
    // ------------------------------------------------------------
    localparam int SB_ERRQ_BIT = 2;
    localparam int SB_WARN_BIT = 3;
    localparam int SB_MAV_BIT = 4;
    localparam int SB_ESB_BIT = 5;
    localparam int SB_RQS_BIT = 6;
    localparam int SB_OPER_BIT = 7;
    localparam logic [7:0] SRE_STORE_MASK = 8'hbf;
    localparam logic [7:0] MASK8_RESET = 8'h00;

    // ------------------------------------------------------------
    // Standard event flag layout
    // ------------------------------------------------------------
    localparam int SE_OPC_BIT = 0;
    localparam int SE_QYE_BIT = 2;
    localparam int SE_DDE_BIT = 3;
    localparam int SE_EXE_BIT = 4;
    localparam int SE_CME_BIT = 5;
    localparam int SE_BUTTON_BIT = 6;
    localparam logic [7:0] SE_RESET = 8'h80;

    // ------------------------------------------------------------
    // Error codes, two's complement
    // ------------------------------------------------------------
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_COMMAND = 16'hff9c;
    localparam logic [15:0] ERR_EXECUTION = 16'hff38;
    localparam logic [15:0] ERR_SETTINGS = 16'hff23;
    localparam logic [15:0] ERR_RANGE = 16'hff22;
    localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
    localparam logic [15:0] ERR_INTERRUPTED = 16'hfe66;
    localparam logic [15:0] ERR_UNTERMINATED = 16'hfe5c;
    localparam logic [15:0] ERR_DEADLOCKED = 16'hfe52;
    localparam int ERRQ_DEPTH = 8;

    // ------------------------------------------------------------
    // Commands from the parser
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CMD_WARN_COND_Q,
        CMD_WARN_EVENT_Q,
        CMD_WARN_MASK_W,
        CMD_WARN_MASK_Q,
        CMD_OP_COND_Q,
        CMD_OP_EVENT_Q,
        CMD_OP_MASK_W,
        CMD_OP_MASK_Q,
        CMD_STATUS_PRESET,
        CMD_STB_Q,
        CMD_SRE_W,
        CMD_SRE_Q,
        CMD_ESE_W,
        CMD_ESE_Q,
        CMD_ESR_Q,
        CMD_CLEAR_STATUS,
        CMD_OPC,
        CMD_ERROR_Q
    } ssr_cmd_t;

endpackage

// ### rtl/ssr_status_reporting.sv
// Status and event reporting core: event latching, summary byte,
// service request, error queue and single-entry response holder.
// Assumes a parser issuing one-cycle commands on the same clock.
`timescale 1ns/1ps
`default_nettype none

module ssr_status_reporting #(
    parameter int QDEPTH = ssr_pkg::ERRQ_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic limitHighFail,
    input wire logic limitLowFail,
    input wire logic capOverload,
    input wire logic overload,
    input wire logic opsBusy,
    input wire logic localButtonRequest,
    input wire logic cmdValid,
    input wire ssr_pkg::ssr_cmd_t cmdCode,
    input wire logic [15:0] cmdData,
    input wire logic msgStart,
    input wire logic rspRead,
    input wire logic errValid,
    input wire logic [15:0] errCode,
    input wire logic pollReq,
    output logic rspValid,
    output logic [15:0] rspData,
    output logic pollValid,
    output logic [7:0] pollData,
    output logic srq
);

    localparam int PTR_W = $clog2(QDEPTH);
    localparam logic [PTR_W:0] Q_LAST = (PTR_W + 1)'(QDEPTH - 1);
    localparam logic [PTR_W:0] Q_FULL = (PTR_W + 1)'(QDEPTH);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] warnLive;
    logic [15:0] warnPrev_reg;
    logic [15:0] warnEvents_reg;
    logic [15:0] warnMask_reg;
    logic [15:0] opPrev_reg;
    logic [15:0] opEvents_reg;
    logic [15:0] opMask_reg;
    logic [7:0] stdFlags_reg;
    logic [7:0] ese_reg;
    logic [7:0] sre_reg;
    logic [7:0] stbNow;
    logic [7:0] seSet;
    logic opcPending_reg;
    logic opcDone;
    logic btnS1_reg;
    logic btnS2_reg;
    logic btnS3_reg;
    logic btnStable_reg;
    logic btnRise;
    logic [15:0] errMem [QDEPTH];
    logic [PTR_W-1:0] wrPtr_reg;
    logic [PTR_W-1:0] rdPtr_reg;
    logic [PTR_W:0] errCount_reg;
    logic [15:0] pushCode;
    logic doPush;
    logic doPop;
    logic isCmd;
    logic clearStatus;
    logic queryHit;
    logic [15:0] queryData;

    function automatic logic [7:0] err_to_flag(input logic [15:0] code);
        logic [7:0] f;
        f = 8'h00;
        unique case (code)
            ssr_pkg::ERR_COMMAND: f[ssr_pkg::SE_CME_BIT] = 1'b1;
            ssr_pkg::ERR_EXECUTION,
            ssr_pkg::ERR_SETTINGS,
            ssr_pkg::ERR_RANGE: f[ssr_pkg::SE_EXE_BIT] = 1'b1;
            ssr_pkg::ERR_OVERFLOW: f[ssr_pkg::SE_DDE_BIT] = 1'b1;
            ssr_pkg::ERR_INTERRUPTED,
            ssr_pkg::ERR_UNTERMINATED,
            ssr_pkg::ERR_DEADLOCKED: f[ssr_pkg::SE_QYE_BIT] = 1'b1;
            default: f = 8'h00;
        endcase
        return f;
    endfunction

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign isCmd = cmdValid;
    assign clearStatus = isCmd && (cmdCode == ssr_pkg::CMD_CLEAR_STATUS);

    // ------------------------------------------------------------
    // Live condition words
    // ------------------------------------------------------------
    always_comb
    begin
        warnLive = 16'h0000;
        warnLive[ssr_pkg::WARN_LIMIT_HIGH_BIT] = limitHighFail;
        warnLive[ssr_pkg::WARN_LIMIT_LOW_BIT] = limitLowFail;
        warnLive[ssr_pkg::WARN_CAP_OVERLOAD_BIT] = capOverload;
        warnLive[ssr_pkg::WARN_OVERLOAD_BIT] = overload;
        warnLive = warnLive & ssr_pkg::WARN_USED_MASK;
    end

    // ------------------------------------------------------------
    // Warning event latch
    // ------------------------------------------------------------
    // Rise sets even in a clearing cycle so no event is lost
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            warnPrev_reg <= 16'h0000;
            warnEvents_reg <= 16'h0000;
        end
        else
        begin
            warnPrev_reg <= warnLive;
            if (clearStatus || (isCmd &&
                cmdCode == ssr_pkg::CMD_WARN_EVENT_Q))
            begin
                warnEvents_reg <= warnLive & ~warnPrev_reg;
            end
            else
            begin
                warnEvents_reg <= warnEvents_reg |
                    (warnLive & ~warnPrev_reg);
            end
        end
    end

    // ------------------------------------------------------------
    // Operation event latch
    // ------------------------------------------------------------
    // Kept structurally alike; its source never asserts
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opPrev_reg <= 16'h0000;
            opEvents_reg <= 16'h0000;
        end
        else
        begin
            opPrev_reg <= ssr_pkg::OP_LIVE_VALUE;
            if (clearStatus || (isCmd &&
                cmdCode == ssr_pkg::CMD_OP_EVENT_Q))
            begin
                opEvents_reg <= ssr_pkg::OP_LIVE_VALUE & ~opPrev_reg;
            end
            else
            begin
                opEvents_reg <= opEvents_reg |
                    (ssr_pkg::OP_LIVE_VALUE & ~opPrev_reg);
            end
        end
    end

    // ------------------------------------------------------------
    // Enable and mask registers
    // ------------------------------------------------------------
    // Clear status leaves these alone
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            warnMask_reg <= ssr_pkg::MASK16_RESET;
            opMask_reg <= ssr_pkg::MASK16_RESET;
            ese_reg <= ssr_pkg::MASK8_RESET;
            sre_reg <= ssr_pkg::MASK8_RESET;
        end
        else if (isCmd)
        begin
            unique case (cmdCode)
                ssr_pkg::CMD_WARN_MASK_W:
                    warnMask_reg <= cmdData &
                        ssr_pkg::ENABLE_STORE_MASK;
                ssr_pkg::CMD_OP_MASK_W:
                    opMask_reg <= cmdData &
                        ssr_pkg::ENABLE_STORE_MASK;
                ssr_pkg::CMD_STATUS_PRESET:
                begin
                    warnMask_reg <= ssr_pkg::MASK16_RESET;
                    opMask_reg <= ssr_pkg::MASK16_RESET;
                end
                ssr_pkg::CMD_ESE_W:
                    ese_reg <= cmdData[7:0];
                ssr_pkg::CMD_SRE_W:
                    sre_reg <= cmdData[7:0] &
                        ssr_pkg::SRE_STORE_MASK;
                default:
                    ese_reg <= ese_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Local button synchroniser
    // ------------------------------------------------------------
    // A change counts only once second and third stages agree
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            btnS1_reg <= 1'b0;
            btnS2_reg <= 1'b0;
            btnS3_reg <= 1'b0;
            btnStable_reg <= 1'b0;
        end
        else
        begin
            btnS1_reg <= localButtonRequest;
            btnS2_reg <= btnS1_reg;
            btnS3_reg <= btnS2_reg;
            if (btnS2_reg == btnS3_reg)
            begin
                btnStable_reg <= btnS3_reg;
            end
        end
    end

    assign btnRise = (btnS2_reg == btnS3_reg) && btnS3_reg &&
        !btnStable_reg;

    // ------------------------------------------------------------
    // Operation complete tracking
    // ------------------------------------------------------------
    assign opcDone = opcPending_reg && !opsBusy;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opcPending_reg <= 1'b0;
        end
        else if (isCmd && cmdCode == ssr_pkg::CMD_OPC)
        begin
            opcPending_reg <= 1'b1;
        end
        else if (opcDone || clearStatus)
        begin
            opcPending_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Standard event flags
    // ------------------------------------------------------------
    always_comb
    begin
        seSet = 8'h00;
        seSet[ssr_pkg::SE_OPC_BIT] = opcDone;
        seSet[ssr_pkg::SE_BUTTON_BIT] = btnRise;
        if (doPush)
        begin
            seSet = seSet | err_to_flag(pushCode);
        end
    end

    // Power-on flag comes from the reset constant
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stdFlags_reg <= ssr_pkg::SE_RESET;
        end
        else if (clearStatus || (isCmd &&
            cmdCode == ssr_pkg::CMD_ESR_Q))
        begin
            stdFlags_reg <= seSet;
        end
        else
        begin
            stdFlags_reg <= stdFlags_reg | seSet;
        end
    end

    // ------------------------------------------------------------
    // Error queue
    // ------------------------------------------------------------
    // Last slot is reserved for the overflow code
    assign doPop = isCmd && (cmdCode == ssr_pkg::CMD_ERROR_Q) &&
        (errCount_reg != '0);
    assign doPush = errValid && (errCount_reg < Q_FULL) &&
        !clearStatus;
    assign pushCode = (errCount_reg == Q_LAST) ?
        ssr_pkg::ERR_OVERFLOW : errCode;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            errCount_reg <= '0;
        end
        else if (clearStatus)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            errCount_reg <= '0;
        end
        else
        begin
            if (doPush)
            begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doPop)
            begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doPush && !doPop)
            begin
                errCount_reg <= errCount_reg + 1'b1;
            end
            else if (doPop && !doPush)
            begin
                errCount_reg <= errCount_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (doPush)
        begin
            errMem[wrPtr_reg] <= pushCode;
        end
    end

    // ------------------------------------------------------------
    // Status byte and service request
    // ------------------------------------------------------------
    always_comb
    begin
        stbNow = 8'h00;
        stbNow[ssr_pkg::SB_ERRQ_BIT] = (errCount_reg != '0);
        stbNow[ssr_pkg::SB_WARN_BIT] =
            |(warnEvents_reg & warnMask_reg);
        stbNow[ssr_pkg::SB_MAV_BIT] = rspValid;
        stbNow[ssr_pkg::SB_ESB_BIT] = |(stdFlags_reg & ese_reg);
        stbNow[ssr_pkg::SB_OPER_BIT] =
            |(opEvents_reg & opMask_reg);
        stbNow[ssr_pkg::SB_RQS_BIT] = |(stbNow & sre_reg);
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            srq <= 1'b0;
        end
        else
        begin
            srq <= stbNow[ssr_pkg::SB_RQS_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pollValid <= 1'b0;
            pollData <= 8'h00;
        end
        else
        begin
            pollValid <= pollReq;
            if (pollReq)
            begin
                pollData <= stbNow;
            end
        end
    end

    // ------------------------------------------------------------
    // Query answers
    // ------------------------------------------------------------
    always_comb
    begin
        queryHit = isCmd;
        queryData = 16'h0000;
        unique case (cmdCode)
            ssr_pkg::CMD_WARN_COND_Q: queryData = warnLive;
            ssr_pkg::CMD_WARN_EVENT_Q: queryData = warnEvents_reg;
            ssr_pkg::CMD_WARN_MASK_Q: queryData = warnMask_reg;
            ssr_pkg::CMD_OP_COND_Q: queryData = ssr_pkg::OP_LIVE_VALUE;
            ssr_pkg::CMD_OP_EVENT_Q: queryData = opEvents_reg;
            ssr_pkg::CMD_OP_MASK_Q: queryData = opMask_reg;
            ssr_pkg::CMD_STB_Q: queryData = {8'h00, stbNow};
            ssr_pkg::CMD_SRE_Q: queryData = {8'h00, sre_reg};
            ssr_pkg::CMD_ESE_Q: queryData = {8'h00, ese_reg};
            ssr_pkg::CMD_ESR_Q: queryData = {8'h00, stdFlags_reg};
            ssr_pkg::CMD_ERROR_Q:
                queryData = doPop ? errMem[rdPtr_reg] :
                    ssr_pkg::ERR_NONE;
            default: queryHit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Response holder
    // ------------------------------------------------------------
    // One entry only: an unread answer is lost to the next message
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rspValid <= 1'b0;
            rspData <= 16'h0000;
        end
        else if (queryHit)
        begin
            rspValid <= 1'b1;
            rspData <= queryData;
        end
        else if (msgStart || rspRead)
        begin
            rspValid <= 1'b0;
            rspData <= 16'h0000;
        end
    end

endmodule

`default_nettype wire

// ### tb/ssr_status_reporting_checker.sv
// Port-level checks of the status reporter.
// Assumes one clock domain and the package command codes.
`timescale 1ns/1ps
`default_nettype none
module ssr_status_reporting_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic limitHighFail,
    input wire logic limitLowFail,
    input wire logic capOverload,
    input wire logic overload,
    input wire logic cmdValid,
    input wire ssr_pkg::ssr_cmd_t cmdCode,
    input wire logic [15:0] cmdData,
    input wire logic msgStart,
    input wire logic rspRead,
    input wire logic pollReq,
    input wire logic rspValid,
    input wire logic [15:0] rspData,
    input wire logic pollValid,
    input wire logic [7:0] pollData,
    input wire logic srq
);
    logic isWrite;
    logic sreWrite;
    // Writes carry no answer
    assign isWrite = cmdCode inside {ssr_pkg::CMD_WARN_MASK_W,
        ssr_pkg::CMD_OP_MASK_W, ssr_pkg::CMD_STATUS_PRESET,
        ssr_pkg::CMD_SRE_W, ssr_pkg::CMD_ESE_W,
        ssr_pkg::CMD_CLEAR_STATUS, ssr_pkg::CMD_OPC};
    assign sreWrite = cmdValid && cmdCode == ssr_pkg::CMD_SRE_W;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    property p_cond;
        cmdValid && cmdCode == ssr_pkg::CMD_WARN_COND_Q |=> rspData ==
            {3'h0, $past(limitHighFail), $past(limitLowFail),
            $past(capOverload), $past(overload), 9'h000};
    endproperty
    a_cond: assert property (p_cond)
        else $error("condition read differs from live state");
    property p_opzero;
        cmdValid && cmdCode inside {ssr_pkg::CMD_OP_COND_Q,
            ssr_pkg::CMD_OP_EVENT_Q} |=> rspData == 16'h0000;
    endproperty
    a_opzero: assert property (p_opzero)
        else $error("operation register not zero");
    property p_top;
        cmdValid && cmdCode inside {ssr_pkg::CMD_WARN_MASK_Q,
            ssr_pkg::CMD_OP_MASK_Q} |=> !rspData[15];
    endproperty
    a_top: assert property (p_top)
        else $error("mask top bit read as one");
    property p_answer;
        cmdValid && !isWrite |=> rspValid;
    endproperty
    a_answer: assert property (p_answer)
        else $error("query gave no response");
    property p_clear;
        (msgStart || rspRead) && !cmdValid |=> !rspValid && rspData == 16'h0000;
    endproperty
    a_clear: assert property (p_clear)
        else $error("response holder not cleared");
    property p_poll;
        pollReq |=> pollValid;
    endproperty
    a_poll: assert property (p_poll)
        else $error("poll not answered");
    property p_pollsrc;
        pollValid |-> $past(pollReq);
    endproperty
    a_pollsrc: assert property (p_pollsrc)
        else $error("poll answer without request");
    property p_unused;
        pollValid |-> pollData[1:0] == 2'b00 && !pollData[7];
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused status byte bit set");
    // Mask cleared: request must drop within two edges
    property p_srqoff;
        sreWrite && cmdData[7:0] == 8'h00 ##1 !sreWrite |=> !srq;
    endproperty
    a_srqoff: assert property (p_srqoff)
        else $error("service request with empty mask");
    c_query: cover property (cmdValid && !isWrite);
    c_rqs: cover property (pollValid && pollData[6]);
    c_srq: cover property (srq);
endmodule
`default_nettype wire

// ### tb/ssr_ctrl_model.sv
// Remote controller model: commands, reads, polls, message starts.
// Assumes the bench calls its tasks; drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module ssr_ctrl_model (
    input wire logic clock,
    output logic cmdValid,
    output ssr_pkg::ssr_cmd_t cmdCode,
    output logic [15:0] cmdData,
    output logic msgStart,
    output logic rspRead,
    output logic pollReq
);
    initial
    begin
        cmdValid = 1'b0;
        cmdCode = ssr_pkg::CMD_STB_Q;
        cmdData = 16'h0000;
        msgStart = 1'b0;
        rspRead = 1'b0;
        pollReq = 1'b0;
    end
    task automatic send(input ssr_pkg::ssr_cmd_t c, input logic [15:0] d,
        input bit rd);
        @(negedge clock);
        cmdCode = c;
        cmdData = d;
        cmdValid = 1'b1;
        @(negedge clock);
        cmdValid = 1'b0;
        rspRead = rd;
        @(negedge clock);
        rspRead = 1'b0;
    endtask
    task automatic poll();
        @(negedge clock);
        pollReq = 1'b1;
        @(negedge clock);
        pollReq = 1'b0;
        @(negedge clock);
    endtask
    task automatic newMsg();
        @(negedge clock);
        msgStart = 1'b1;
        @(negedge clock);
        msgStart = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench: controller model, queued expectations.
// Assumes QDEPTH of 4 and a 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock;
    logic rst_b;
    logic limitHighFail;
    logic limitLowFail;
    logic capOverload;
    logic overload;
    logic opsBusy;
    logic localButtonRequest;
    logic errValid;
    logic [15:0] errCode;
    logic cmdValid;
    ssr_pkg::ssr_cmd_t cmdCode;
    logic [15:0] cmdData;
    logic msgStart;
    logic rspRead;
    logic pollReq;
    logic rspValid;
    logic [15:0] rspData;
    logic pollValid;
    logic [7:0] pollData;
    logic srq;
    bit qFlag = 1'b0;
    bit qTaken = 1'b0;
    logic [15:0] expQ[$];
    int err_total = 0;
    int checks_done = 0;
    logic [3:0] r;
    logic [3:0] prev;
    logic [15:0] codes[7] = '{ssr_pkg::ERR_COMMAND, ssr_pkg::ERR_EXECUTION,
        ssr_pkg::ERR_SETTINGS, ssr_pkg::ERR_RANGE, ssr_pkg::ERR_INTERRUPTED,
        ssr_pkg::ERR_UNTERMINATED, ssr_pkg::ERR_DEADLOCKED};
    int bits[7] = '{5, 4, 4, 4, 2, 2, 2};
    ssr_status_reporting #(.QDEPTH(4)) ssr_status_reporting_i (.clock,
        .rst_b, .limitHighFail, .limitLowFail, .capOverload, .overload,
        .opsBusy, .localButtonRequest, .cmdValid, .cmdCode, .cmdData,
        .msgStart, .rspRead, .errValid, .errCode, .pollReq, .rspValid,
        .rspData, .pollValid, .pollData, .srq);
    ssr_ctrl_model ssr_ctrl_model_i (.clock, .cmdValid, .cmdCode, .cmdData,
        .msgStart, .rspRead, .pollReq);
    // ----------------------------------------------------
    // Helpers
    // ----------------------------------------------------
    task automatic check(input string s, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic q(input ssr_pkg::ssr_cmd_t c, input logic [15:0] e,
        input bit rd = 1'b1);
        expQ.push_back(e);
        qFlag = 1'b1;
        ssr_ctrl_model_i.send(c, 16'h0000, rd);
        qFlag = 1'b0;
    endtask
    task automatic w(input ssr_pkg::ssr_cmd_t c, input logic [15:0] d);
        ssr_ctrl_model_i.send(c, d, 1'b1);
    endtask
    task automatic pl(input logic [15:0] e);
        expQ.push_back(e);
        ssr_ctrl_model_i.poll();
    endtask
    task automatic err(input logic [15:0] c);
        @(negedge clock);
        errCode = c;
        errValid = 1'b1;
        @(negedge clock);
        errValid = 1'b0;
    endtask
    task automatic live(input logic [3:0] v);
        @(negedge clock);
        {limitHighFail, limitLowFail, capOverload, overload} = v;
        repeat (3) @(negedge clock);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Answers are compared on the falling edge after they land
    always @(posedge clock)
    begin
        qTaken <= cmdValid && qFlag;
    end
    always @(negedge clock)
    begin
        if (qTaken)
            check("response", rspData, expQ.pop_front());
        else if (pollValid)
            check("status byte", {8'h00, pollData}, expQ.pop_front());
    end
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        #50000;
        err_total++;
        report_and_stop();
    end
    initial
    begin
        rst_b = 1'b0;
        {limitHighFail, limitLowFail, capOverload, overload} = 4'h0;
        opsBusy = 1'b0;
        localButtonRequest = 1'b0;
        errValid = 1'b0;
        errCode = 16'h0000;
        prev = 4'h0;
        void'($urandom(84));
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        q(ssr_pkg::CMD_ESR_Q, 16'h0080);
        q(ssr_pkg::CMD_ESR_Q, 16'h0000);
        pl(16'h0000);
        done("power-on");
        repeat (8)
        begin
            r = 4'($urandom);
            live(r);
            q(ssr_pkg::CMD_WARN_COND_Q, {3'h0, r, 9'h000});
            q(ssr_pkg::CMD_WARN_EVENT_Q, {3'h0, r & ~prev, 9'h000});
            prev = r;
        end
        live(4'h0);
        live(4'hf);
        live(4'h1);
        q(ssr_pkg::CMD_WARN_EVENT_Q, 16'h1e00);
        q(ssr_pkg::CMD_WARN_EVENT_Q, 16'h0000);
        done("warnings");
        w(ssr_pkg::CMD_WARN_MASK_W, 16'hffff);
        q(ssr_pkg::CMD_WARN_MASK_Q, 16'h7fff);
        w(ssr_pkg::CMD_OP_MASK_W, 16'hffff);
        q(ssr_pkg::CMD_OP_MASK_Q, 16'h7fff);
        q(ssr_pkg::CMD_OP_COND_Q, 16'h0000);
        q(ssr_pkg::CMD_OP_EVENT_Q, 16'h0000);
        live(4'h0);
        live(4'h1);
        w(ssr_pkg::CMD_SRE_W, 16'h0008);
        pl(16'h0048);
        check("srq", {15'h0, srq}, 16'h0001);
        q(ssr_pkg::CMD_STB_Q, 16'h0048);
        w(ssr_pkg::CMD_WARN_MASK_W, 16'h1000);
        pl(16'h0000);
        check("srq", {15'h0, srq}, 16'h0000);
        w(ssr_pkg::CMD_STATUS_PRESET, 16'h0000);
        q(ssr_pkg::CMD_WARN_MASK_Q, 16'h0000);
        q(ssr_pkg::CMD_OP_MASK_Q, 16'h0000);
        done("summary");
        w(ssr_pkg::CMD_ESE_W, 16'h0020);
        q(ssr_pkg::CMD_ESE_Q, 16'h0020);
        err(ssr_pkg::ERR_COMMAND);
        pl(16'h0024);
        w(ssr_pkg::CMD_SRE_W, 16'h0020);
        pl(16'h0064);
        q(ssr_pkg::CMD_SRE_Q, 16'h0020);
        w(ssr_pkg::CMD_SRE_W, 16'h0000);
        w(ssr_pkg::CMD_CLEAR_STATUS, 16'h0000);
        q(ssr_pkg::CMD_ESE_Q, 16'h0020);
        q(ssr_pkg::CMD_WARN_EVENT_Q, 16'h0000);
        q(ssr_pkg::CMD_ERROR_Q, 16'h0000);
        done("clear");
        for (int i = 0; i < 7; i++)
        begin
            err(codes[i]);
            q(ssr_pkg::CMD_ESR_Q, 16'h0001 << bits[i]);
            q(ssr_pkg::CMD_ERROR_Q, codes[i]);
        end
        // Fifth push meets a full queue and is dropped
        for (int i = 0; i < 5; i++)
            err(codes[i]);
        q(ssr_pkg::CMD_ESR_Q, 16'h0038);
        for (int i = 0; i < 3; i++)
            q(ssr_pkg::CMD_ERROR_Q, codes[i]);
        q(ssr_pkg::CMD_ERROR_Q, ssr_pkg::ERR_OVERFLOW);
        q(ssr_pkg::CMD_ERROR_Q, 16'h0000);
        done("errors");
        opsBusy = 1'b1;
        w(ssr_pkg::CMD_OPC, 16'h0000);
        q(ssr_pkg::CMD_ESR_Q, 16'h0000);
        opsBusy = 1'b0;
        repeat (3) @(negedge clock);
        q(ssr_pkg::CMD_ESR_Q, 16'h0001);
        localButtonRequest = 1'b1;
        repeat (8) @(negedge clock);
        localButtonRequest = 1'b0;
        q(ssr_pkg::CMD_ESR_Q, 16'h0040);
        done("flags");
        q(ssr_pkg::CMD_ESE_Q, 16'h0020, 1'b0);
        pl(16'h0010);
        ssr_ctrl_model_i.newMsg();
        check("holder", {15'h0, rspValid}, 16'h0000);
        pl(16'h0000);
        done("output queue");
        report_and_stop();
    end
endmodule
bind ssr_status_reporting ssr_status_reporting_checker chk_i (.clock,
    .rst_b, .limitHighFail, .limitLowFail, .capOverload, .overload,
    .cmdValid, .cmdCode, .cmdData, .msgStart, .rspRead, .pollReq,
    .rspValid, .rspData, .pollValid, .pollData, .srq);
`default_nettype wire
